// >>> rtl/osl_loader.sv
`timescale 1ns/1ps

// ****************************************
// Byte FIFO between link and RAM writer
// ****************************************
module osl_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   input  wire logic             mclk,
   input  wire logic             reset_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [AW:0]      wr_r;
   logic [AW:0]      rd_r;

   assign in_ready  = (wr_r[AW-1:0] != rd_r[AW-1:0]) || (wr_r[AW] == rd_r[AW]);
   assign out_valid = (wr_r != rd_r);
   assign out_data  = mem[rd_r[AW-1:0]];

   always_ff @(posedge mclk) begin
      if (in_valid && in_ready) begin
         mem[wr_r[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wr_r <= '0;
         rd_r <= '0;
      end else begin
         if (in_valid && in_ready) wr_r <= wr_r + 1'b1;
         if (out_valid && out_ready) rd_r <= rd_r + 1'b1;
      end
   end
endmodule // osl_fifo

// Operation
// R1 - Intensity pin high on characters or intense windows while clock-out is off
// R2 - With tri-state select, high intensity shows as released colour pins
// R3 - Clock-out gives 32 or 64 times line rate, 50/50, synced to hsync
// R4 - Blanking covers characters and windows, or characters only when selected
// R5 - Blanking pin released after reset and whenever nothing shows
// R6 - Colour pins released after reset and on low intensity with tri-state select
// R7 - Refresh reads the RAM by itself; serial writes wait for free cycles
// R8 - Serial logic runs on the device clock; host supplies locked hsync
// R9 - Two-wire slave answers only chip address 7A; master keeps 100 kbps (bench host sends a bit every 800 ns)
// R10 - Address match and every data byte acknowledged low on ninth clock (no data acknowledge while the FIFO is full)
// R11 - Master starts with START plus address and ends with STOP
// R12 - Nothing is shown until display activate is set
// R13 - Master holds select low across each whole byte of a transfer
// R14 - Select mode samples on rising clock, stores byte on falling clock
// R15 - Select mode takes row, column and data straight after select falls
// R16 - Address byte with top bit one is a row, zero a column
// R17 - Column bit six chooses streaming format, zero single-byte formats
// R18 - Single-byte formats write each data byte at the addressed location
// R19 - Streaming treats every later byte as data and advances the location
// R20 - Host never leaves streaming inside one transfer
// R21 - Rows 0-14 columns 0-29 hold codes; columns 30,31 row control (refresh reads row control from column 30 only)
// R22 - Double-height row n fills screen rows n and n+1, later rows shift
// R23 - Double-width rows show only even memory columns
// R24 - Row number from low four bits, column from low five bits
module osl_loader
   import osl_pkg::*;
#(
   parameter int FIFO_DEPTH = OSL_FIFO_DEPTH
) (
   input  wire logic       mclk,
   input  wire logic       reset_n,
   input  wire logic       spi_mode,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   input  wire logic       ss_n_in,
   input  wire logic       hsync_flyback_in,
   input  wire logic       vsync_flyback_in,
   input  wire logic       dots768,
   input  wire logic       display_activate,
   input  wire logic       cout_select,
   input  wire logic       tristate_sel,
   input  wire logic       blanking_char_only,
   input  wire logic       window_on_in,
   input  wire logic       window_int_in,
   input  wire logic [2:0] window_rgb_in,
   output logic            int_cout_out,
   output logic            fast_blanking_out,
   output logic            fast_blanking_oe,
   output logic      [2:0] rgb_out,
   output logic      [2:0] rgb_oe
);
   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [3:0]    s1_r;
   logic [3:0]    s2_r;
   logic [3:0]    s3_r;
   logic          scl_rise;
   logic          scl_fall;
   logic          sda_rise;
   logic          sda_fall;
   logic          hs_fall;
   logic          vs_fall;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         s1_r <= 4'hF;
         s2_r <= 4'hF;
         s3_r <= 4'hF;
      end else begin
         s1_r <= {vsync_flyback_in, hsync_flyback_in, sda_in, scl_in}; // see R8
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   assign scl_rise = s2_r[0] && !s3_r[0];
   assign scl_fall = !s2_r[0] && s3_r[0];
   assign sda_rise = s2_r[1] && !s3_r[1];
   assign sda_fall = !s2_r[1] && s3_r[1];
   assign hs_fall  = !s2_r[2] && s3_r[2];
   assign vs_fall  = !s2_r[3] && s3_r[3];

   // ****************************************
   // Serial receiver
   // ****************************************
   osl_link_st_t  lst_r;
   logic [7:0]    sh_r;
   logic [3:0]    bit_r;
   logic          first_r;
   logic          push_r;
   osl_word_t     push_w_r;
   logic          fifo_in_ready;
   logic          ss_n_s;
   logic          ss_s1_r;
   logic          ss_s2_r;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ss_s1_r <= 1'b1;
         ss_s2_r <= 1'b1;
      end else begin
         ss_s1_r <= ss_n_in;
         ss_s2_r <= ss_s1_r;
      end
   end
   assign ss_n_s = ss_s2_r;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         lst_r    <= I_IDLE;
         sh_r     <= 8'h00;
         bit_r    <= 4'h0;
         first_r  <= 1'b0;
         push_r   <= 1'b0;
         push_w_r <= '0;
         sda_oe   <= 1'b0;
         sda_out  <= 1'b0;
      end else begin
         push_r <= 1'b0;
         if (spi_mode) begin
            sda_oe <= 1'b0;
            if (ss_n_s) begin
               bit_r   <= 4'h0;
               first_r <= 1'b1;
            end else if (scl_rise) begin // see R14
               sh_r  <= {sh_r[6:0], s2_r[1]};
               bit_r <= bit_r + 4'h1;
            end else if (scl_fall && bit_r == OSL_BYTE_BITS) begin // see R14
               push_r   <= fifo_in_ready; // see R15
               push_w_r <= '{first: first_r, data: sh_r};
               first_r  <= 1'b0;
               bit_r    <= 4'h0;
            end
         end else if (s2_r[0] && sda_fall) begin // START
            lst_r   <= I_ADDR;
            bit_r   <= 4'h0;
            first_r <= 1'b1;
            sda_oe  <= 1'b0;
         end else if (s2_r[0] && sda_rise) begin // STOP
            lst_r  <= I_IDLE;
            sda_oe <= 1'b0;
         end else begin
            case (lst_r)
               I_ADDR, I_DATA: begin
                  if (scl_rise) begin
                     sh_r  <= {sh_r[6:0], s2_r[1]};
                     bit_r <= bit_r + 4'h1;
                  end else if (scl_fall && bit_r == OSL_BYTE_BITS) begin
                     bit_r <= 4'h0;
                     if (lst_r == I_ADDR) begin
                        // Full byte compare: write direction only
                        if (sh_r == OSL_CHIP_ADDR) begin // see R9
                           lst_r  <= I_ACK;
                           sda_oe <= 1'b1; // see R10
                        end else begin
                           lst_r <= I_SKIP;
                        end
                     end else if (fifo_in_ready) begin
                        // No room means no acknowledge, host must STOP
                        push_r   <= 1'b1;
                        push_w_r <= '{first: first_r, data: sh_r};
                        first_r  <= 1'b0;
                        lst_r    <= I_ACK;
                        sda_oe   <= 1'b1; // see R10
                     end else begin
                        lst_r <= I_SKIP;
                     end
                  end
               end
               I_ACK: begin
                  if (scl_fall) begin
                     sda_oe <= 1'b0;
                     lst_r  <= I_DATA;
                  end
               end
               I_IDLE, I_SKIP: begin
                  sda_oe <= 1'b0;
               end
               default: begin
                  lst_r  <= I_IDLE;
                  sda_oe <= 1'b0;
               end
            endcase
         end
      end
   end

   // ****************************************
   // FIFO and packet decoder
   // ****************************************
   osl_word_t     pop_w;
   logic          pop_valid;
   logic          refresh_req;
   logic          pop;
   osl_parse_st_t pst_r;
   logic          stream_r;
   logic [3:0]    row_r;
   logic [4:0]    col_r;
   logic          ram_we;
   logic          as_addr;

   osl_fifo #(.WIDTH($bits(osl_word_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
      .mclk      (mclk),
      .reset_n   (reset_n),
      .in_valid  (push_r),
      .in_ready  (fifo_in_ready),
      .in_data   (push_w_r),
      .out_valid (pop_valid),
      .out_ready (!refresh_req),
      .out_data  (pop_w)
   );

   assign pop     = pop_valid && !refresh_req; // see R7
   assign as_addr = !(stream_r && !pop_w.first) && (pop_w.first || pst_r == P_ADDR);
   assign ram_we  = pop && !as_addr;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pst_r    <= P_ADDR;
         stream_r <= 1'b0;
         row_r    <= 4'h0;
         col_r    <= 5'h00;
      end else if (pop) begin
         if (as_addr) begin
            if (pop_w.first) stream_r <= 1'b0;
            if (pop_w.data[7]) begin // see R16
               row_r <= pop_w.data[3:0]; // see R24
            end else begin
               col_r    <= pop_w.data[4:0]; // see R24
               stream_r <= pop_w.data[6]; // see R17
               pst_r    <= P_INFO;
            end
         end else begin
            pst_r <= P_ADDR; // see R18
            if (stream_r) begin // see R19
               col_r <= col_r + 5'h01;
               if (col_r == OSL_LAST_COL) row_r <= row_r + 4'h1;
            end
         end
      end
   end

   // ****************************************
   // Display RAM, one port, refresh first
   // ****************************************
   logic [7:0]    ram [0:OSL_RAM_WORDS-1];
   logic [8:0]    rd_addr;
   logic [7:0]    rd_data_r;

   always_ff @(posedge mclk) begin
      if (ram_we) begin
         ram[{row_r, col_r}] <= pop_w.data; // see R18 R21
      end
      if (refresh_req) begin
         rd_data_r <= ram[rd_addr]; // see R7
      end
   end

   // ****************************************
   // Screen refresh
   // ****************************************
   logic [4:0]    mem_row_r;
   logic          dh_phase_r;
   logic [4:0]    line_r;
   logic [7:0]    hcnt_r;
   logic          hact_r;
   logic [4:0]    cyc_r;
   logic [4:0]    cell_r;
   logic [7:0]    ctrl_r;
   logic [7:0]    code_r;
   logic          ctrl_fetch_r;
   logic          ctrl_load_r;
   logic          code_load_r;
   logic          row_vis;
   logic [4:0]    cyc_last;
   logic [4:0]    mem_col;

   assign row_vis  = mem_row_r < 5'(OSL_ROWS);
   assign cyc_last = ctrl_r[0] ? 5'({OSL_CELL_CYC, 1'b0} - 5'h01) : 5'(OSL_CELL_CYC - 4'h1);
   assign mem_col  = ctrl_r[0] ? {cell_r[3:0], 1'b0} : cell_r; // see R23
   assign refresh_req = ctrl_fetch_r || (hact_r && cyc_r == 5'h00);
   assign rd_addr  = ctrl_fetch_r ? {mem_row_r[3:0], OSL_CTRL_COL} : {mem_row_r[3:0], mem_col};

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         mem_row_r  <= 5'h00;
         dh_phase_r <= 1'b0;
         line_r     <= 5'h00;
      end else if (vs_fall) begin
         mem_row_r  <= 5'h00;
         dh_phase_r <= 1'b0;
         line_r     <= 5'h00;
      end else if (hs_fall && row_vis) begin
         if (line_r == OSL_CHAR_LINES - 5'h01) begin
            line_r <= 5'h00;
            if (ctrl_r[1] && !dh_phase_r) begin // see R22
               dh_phase_r <= 1'b1;
            end else begin
               dh_phase_r <= 1'b0;
               mem_row_r  <= mem_row_r + 5'h01;
            end
         end else begin
            line_r <= line_r + 5'h01;
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         hcnt_r       <= 8'h00;
         hact_r       <= 1'b0;
         cyc_r        <= 5'h00;
         cell_r       <= 5'h00;
         ctrl_fetch_r <= 1'b0;
         ctrl_load_r  <= 1'b0;
         code_load_r  <= 1'b0;
         ctrl_r       <= 8'h00;
         code_r       <= 8'h00;
      end else begin
         ctrl_fetch_r <= hs_fall;
         ctrl_load_r  <= ctrl_fetch_r;
         code_load_r  <= hact_r && cyc_r == 5'h00;
         if (ctrl_load_r) ctrl_r <= rd_data_r;
         if (code_load_r) code_r <= rd_data_r;
         if (hs_fall) begin
            hcnt_r <= 8'h00;
            hact_r <= 1'b0;
            code_r <= 8'h00;
         end else if (hcnt_r != OSL_H_START) begin
            hcnt_r <= hcnt_r + 8'h01;
            if (hcnt_r == OSL_H_START - 8'h01) begin
               hact_r <= row_vis;
               cyc_r  <= 5'h00;
               cell_r <= 5'h00;
            end
         end else if (hact_r) begin
            if (cyc_r == cyc_last) begin
               cyc_r <= 5'h00;
               if (cell_r == 5'(ctrl_r[0] ? OSL_COLS / 2 - 1 : OSL_COLS - 1)) begin
                  hact_r <= 1'b0;
                  code_r <= 8'h00;
               end
               cell_r <= cell_r + 5'h01;
            end else begin
               cyc_r <= cyc_r + 5'h01;
            end
         end
      end
   end

   // ****************************************
   // Clock-out divider, restarted by hsync
   // ****************************************
   logic [15:0]   per_cnt_r;
   logic [15:0]   per_r;
   logic [15:0]   half_cnt_r;
   logic [15:0]   half_raw;
   logic [15:0]   half;
   logic          cout_r;

   // Floor of one cycle so a short or missing line cannot stall the pin
   assign half_raw = dots768 ? (per_r >> OSL_COUT_SH768) : (per_r >> OSL_COUT_SH384);
   assign half     = (half_raw == 16'h0000) ? 16'h0001 : half_raw;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         per_cnt_r  <= 16'h0000;
         per_r      <= 16'h0000;
         half_cnt_r <= 16'h0000;
         cout_r     <= 1'b0;
      end else if (hs_fall) begin // see R3
         per_cnt_r  <= 16'h0001;
         per_r      <= per_cnt_r;
         half_cnt_r <= 16'h0001;
         cout_r     <= 1'b1;
      end else begin
         per_cnt_r <= per_cnt_r + 16'h0001;
         if (half_cnt_r >= half) begin // see R3
            half_cnt_r <= 16'h0001;
            cout_r     <= !cout_r;
         end else begin
            half_cnt_r <= half_cnt_r + 16'h0001;
         end
      end
   end

   // ****************************************
   // Output pins
   // ****************************************
   logic          char_on;
   logic          win_on;
   logic          inten;
   logic [2:0]    colour;

   assign char_on = display_activate && hact_r && code_r[6:0] != 7'h00; // see R12
   assign win_on  = display_activate && window_on_in; // see R12
   assign inten   = char_on || (win_on && window_int_in);
   assign colour  = char_on ? (code_r[7] ? ctrl_r[4:2] : ctrl_r[7:5]) :
                    (win_on ? window_rgb_in : 3'h0);

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         int_cout_out      <= 1'b0;
         fast_blanking_out <= 1'b0;
         fast_blanking_oe  <= 1'b0;
         rgb_out           <= 3'h0;
         rgb_oe            <= 3'h0;
      end else begin
         int_cout_out      <= cout_select ? cout_r : inten; // see R1 R3
         fast_blanking_out <= 1'b1;
         fast_blanking_oe  <= blanking_char_only ? char_on : (char_on || win_on); // see R4 R5
         if (tristate_sel) begin
            rgb_out <= 3'h0;
            rgb_oe  <= inten ? ~colour : 3'h0; // see R2 R6
         end else begin
            rgb_out <= colour;
            rgb_oe  <= 3'h7; // see R6
         end
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   a_no_collide: assert property (ram_we |-> !refresh_req) // see R7
      else $error("Serial write collided with refresh read");
   a_ack_low: assert property (sda_oe |-> !sda_out && !spi_mode) // see R10
      else $error("Acknowledge not driven low");
   a_ack_cause: assert property ($rose(sda_oe) |-> $past(scl_fall) && $past(bit_r) == 4'h8) // see R10
      else $error("Acknowledge outside ninth clock");
   a_addr_match: assert property ($rose(sda_oe) && $past(lst_r) == I_ADDR |-> $past(sh_r) == 8'h7A) // see R9
      else $error("Acknowledged foreign address");
   a_row_decode: assert property (pop && as_addr && pop_w.data[7] |=> row_r == $past(pop_w.data[3:0])) // see R16
      else $error("Row address not taken");
   a_stream_step: assert property (ram_we && stream_r |=> col_r == $past(col_r) + 5'h01) // see R19
      else $error("Streaming location not advanced");
   a_fb_release: assert property (!display_activate |=> !fast_blanking_oe) // see R5
      else $error("Blanking driven with display off");
   a_rgb_lowint: assert property (tristate_sel && !inten |=> rgb_oe == 3'h0) // see R6
      else $error("Colour pins driven at low intensity");
   a_spi_frame: assert property (spi_mode && ss_n_s |=> !push_r) // see R15
      else $error("Select-mode byte stored outside select");
   a_dbl_width: assert property (hact_r && cyc_r == 5'h00 && ctrl_r[0] |-> !rd_addr[0]) // see R23
      else $error("Odd column fetched on double-width row");

   c_i2c_ack: cover property (lst_r == I_DATA ##1 lst_r == I_ACK);
   c_stream: cover property (ram_we && stream_r ##[1:200] ram_we);
   c_spi_byte: cover property (spi_mode && push_r);
   c_dbl_height: cover property (dh_phase_r && char_on);

endmodule // osl_loader

// >>> rtl/osl_pkg.sv
package osl_pkg;

   // ****************************************
   // Memory map
   // ****************************************
   localparam int          OSL_ROWS       = 15;
   localparam int          OSL_COLS       = 30;
   localparam logic [4:0]  OSL_CTRL_COL   = 5'h1E;
   localparam logic [4:0]  OSL_LAST_COL   = 5'h1F;
   localparam int          OSL_RAM_WORDS  = 512;

   // ****************************************
   // Serial link
   // ****************************************
   localparam logic [7:0]  OSL_CHIP_ADDR  = 8'h7A;
   localparam logic [3:0]  OSL_BYTE_BITS  = 4'h8;
   localparam int          OSL_FIFO_DEPTH = 16;

   // ****************************************
   // Screen timing, in mclk cycles and lines
   // ****************************************
   localparam logic [7:0]  OSL_H_START    = 8'h20;
   localparam logic [3:0]  OSL_CELL_CYC   = 4'h4;
   localparam logic [4:0]  OSL_CHAR_LINES = 5'h12;
   localparam int          OSL_COUT_SH384 = 6;
   localparam int          OSL_COUT_SH768 = 7;

   // ****************************************
   // Types
   // ****************************************
   typedef struct packed {
      logic       first;
      logic [7:0] data;
   } osl_word_t;

   typedef enum logic [4:0] {
      I_IDLE = 5'b00001,
      I_ADDR = 5'b00010,
      I_ACK  = 5'b00100,
      I_DATA = 5'b01000,
      I_SKIP = 5'b10000
   } osl_link_st_t;

   typedef enum logic [1:0] {
      P_ADDR = 2'b01,
      P_INFO = 2'b10
   } osl_parse_st_t;

endpackage

// >>> bench/osl_host.sv
`timescale 1ns/1ps

// ****************************************
// Host serial master, both link flavours
// ****************************************
module osl_host (
   input  wire logic mclk,
   input  wire logic sda_line,
   output logic      scl,
   output logic      sda,
   output logic      ss_n
);
   initial begin
      scl = 1'b1;
      sda = 1'b1;
      ss_n = 1'b1;
   end

   // Four mclk per phase, above the synchroniser minimum
   task automatic half();
      repeat (4) @(posedge mclk);
   endtask

   task automatic start();
      sda <= 1'b0;
      half();
      scl <= 1'b0;
      half();
   endtask

   task automatic stop();
      sda <= 1'b0;
      half();
      scl <= 1'b1;
      half();
      sda <= 1'b1;
      half();
   endtask

   // One bit in 800 ns: data moves mid-way through the low phase, MSB first
   task automatic bit_out(input logic v);
      repeat (2) @(posedge mclk);
      sda <= v;
      repeat (2) @(posedge mclk);
      scl <= 1'b1;
      half();
      scl <= 1'b0;
   endtask

   task automatic tx(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) bit_out(b[i]);
      repeat (2) @(posedge mclk);
      sda <= 1'b1;
      repeat (2) @(posedge mclk);
      scl <= 1'b1;
      half();
      ack = (sda_line === 1'b0);
      scl <= 1'b0;
   endtask

   task automatic spi_open();
      scl <= 1'b0;
      half();
      ss_n <= 1'b0;
      half();
   endtask

   task automatic spi_tx(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) bit_out(b[i]);
   endtask

   // Select stays low past the last falling edge so the final byte lands
   task automatic spi_close();
      half();
      ss_n <= 1'b1;
      sda <= ~sda;
      half();
   endtask
endmodule // osl_host

// >>> bench/tb.sv
`timescale 1ns/1ps

module tb;
   logic       mclk = 1'b0;
   logic       reset_n = 1'b0;
   logic       spi_mode = 1'b0;
   logic       hs = 1'b1;
   logic       vs = 1'b1;
   logic       dots768 = 1'b0;
   logic       act = 1'b0;
   logic       cout = 1'b0;
   logic       tri3 = 1'b0;
   logic       bco = 1'b0;
   logic       won = 1'b0;
   logic       wint = 1'b0;
   logic [2:0] wrgb = 3'h0;
   logic [9:0] hcnt = 10'h000;
   logic [4:0] line = 5'h00;
   logic       h_scl, h_sda, h_ss_n, sda_out, sda_oe, icout, fb, fb_oe, ack, seen;
   logic [2:0] rgb_out, rgb_oe;
   wire        sda_w = h_sda & ~(sda_oe & ~sda_out);
   int         fails = 0;
   int         tests_run = 0;
   logic [7:0] i2c_seq [4] = '{osl_pkg::OSL_CHIP_ADDR, 8'h80, 8'h1E, 8'hE0};
   logic [7:0] spi_seq [4] = '{8'h80, 8'h40, 8'h05, 8'h06};

   always #50 mclk = ~mclk;

   // 640 mclk lines give 15.6 kHz sync, 24 lines a field
   always @(posedge mclk) begin
      hcnt <= (hcnt == 10'h27F) ? 10'h000 : hcnt + 10'h001;
      if (hcnt == 10'h27F) line <= (line == 5'h17) ? 5'h00 : line + 5'h01;
      hs <= (hcnt >= 10'h008);
      vs <= (line != 5'h00);
   end

   osl_host osl_host_i (.mclk(mclk), .sda_line(sda_w), .scl(h_scl), .sda(h_sda), .ss_n(h_ss_n));

   osl_loader osl_loader_i (
      .mclk(mclk), .reset_n(reset_n), .spi_mode(spi_mode), .scl_in(h_scl),
      .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .ss_n_in(h_ss_n),
      .hsync_flyback_in(hs), .vsync_flyback_in(vs), .dots768(dots768),
      .display_activate(act), .cout_select(cout), .tristate_sel(tri3),
      .blanking_char_only(bco), .window_on_in(won), .window_int_in(wint),
      .window_rgb_in(wrgb), .int_cout_out(icout), .fast_blanking_out(fb),
      .fast_blanking_oe(fb_oe), .rgb_out(rgb_out), .rgb_oe(rgb_oe));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic give_verdict();
      $display("fails=%0d tests_run=%0d", fails, tests_run);
      if (fails == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic at_h(input logic [9:0] n);
      do @(posedge mclk); while (hcnt != n);
   endtask

   // Length of one high phase of the clock-out pin
   task automatic meas(input int exp);
      int n;
      n = 0;
      at_h(10'h028);
      for (int k = 0; k < 300 && icout !== 1'b0; k++) @(posedge mclk);
      for (int k = 0; k < 300 && icout !== 1'b1; k++) @(posedge mclk);
      while (icout === 1'b1 && n < 300) begin
         n++;
         @(posedge mclk);
      end
      chk(8'(n), 8'(exp));
   endtask

   initial begin
      #8_000_000;
      fails++;
      give_verdict();
   end

   initial begin
      void'($urandom(2));
      repeat (6) @(posedge mclk);
      chk(8'({fb_oe, rgb_oe}), 8'h00);
      reset_n <= 1'b1;
      repeat (4) @(posedge mclk);
      chk(8'({fb_oe, rgb_oe, rgb_out}), 8'h38);
      // ****************************************
      // Two-wire writes: foreign address, then row 0 control
      // ****************************************
      osl_host_i.start();
      osl_host_i.tx(8'h7B, ack);
      chk(8'(ack), 8'h00);
      osl_host_i.stop();
      osl_host_i.start();
      foreach (i2c_seq[i]) begin
         osl_host_i.tx(i2c_seq[i], ack);
         chk(8'(ack), 8'h01);
      end
      osl_host_i.stop();
      // ****************************************
      // Select link, streaming into row 0
      // ****************************************
      @(posedge mclk);
      spi_mode <= 1'b1;
      osl_host_i.spi_open();
      foreach (spi_seq[i]) osl_host_i.spi_tx(spi_seq[i]);
      osl_host_i.spi_close();
      // ****************************************
      // Character shows in colour 7 once activated
      // ****************************************
      act <= 1'b1;
      bco <= 1'b1;
      seen = 1'b0;
      repeat (19200) begin
         @(posedge mclk);
         if (fb_oe === 1'b1 && fb === 1'b1 && rgb_oe === 3'h7 && rgb_out === 3'h7) seen = 1'b1;
      end
      chk(8'(seen), 8'h01);
      // ****************************************
      // Windows ahead of the character cells
      // ****************************************
      for (int i = 0; i < 10; i++) begin
         at_h(10'h258);
         act <= (i > 1);
         won <= 1'b1;
         wint <= 1'($urandom);
         wrgb <= 3'($urandom);
         tri3 <= 1'($urandom);
         bco <= 1'($urandom);
         at_h(10'h014);
         if (i < 2) begin
            chk(8'({fb_oe, rgb_oe, rgb_out}), tri3 ? 8'h00 : 8'h38);
         end else begin
            chk(8'(icout), 8'(wint));
            if (bco) chk(8'(fb_oe & fb), 8'h00);
            else chk(8'({fb_oe, fb}), 8'h03);
            if (!tri3) chk(8'({rgb_oe, rgb_out}), 8'({3'h7, wrgb}));
            else chk(8'(rgb_oe), wint ? {5'h00, ~wrgb} : 8'h00);
         end
      end
      // ****************************************
      // Clock-out in both resolutions
      // ****************************************
      won <= 1'b0;
      cout <= 1'b1;
      for (int m = 0; m < 2; m++) begin
         dots768 <= m[0];
         at_h(10'h000);
         at_h(10'h000);
         meas(m ? 5 : 10);
      end
      give_verdict();
   end
endmodule // tb
